// ==== hw/tmc_edge_sync.sv ====
`default_nettype none
module tmc_edge_sync (
    input  wire logic i_clk,
    input  wire logic i_arst_n,
    input  wire logic i_pin,
    output logic      o_rise,
    output logic      o_fall
);
    logic meta_ff;
    logic sync_ff;
    logic prev_ff;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            prev_ff <= 1'b0;
        end else begin
            meta_ff <= i_pin;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    // One pulse per edge, taken only behind the second stage
    assign o_rise = sync_ff & ~prev_ff;
    assign o_fall = ~sync_ff & prev_ff;
endmodule : tmc_edge_sync
`default_nettype wire

// ==== hw/tmc_pkg.sv ====
`default_nettype none
package tmc_pkg;
    localparam int          ADDR_W        = 8;
    localparam logic [7:0]  OFF_CTRL0     = 8'h00;
    localparam logic [7:0]  OFF_CTRL1     = 8'h04;
    localparam logic [7:0]  OFF_CNT_L     = 8'h08;
    localparam logic [7:0]  OFF_CNT_H     = 8'h0C;
    localparam logic [7:0]  OFF_CMPA_L    = 8'h10;
    localparam logic [7:0]  OFF_CMPA_H    = 8'h14;
    localparam logic [7:0]  OFF_CMPP      = 8'h18;
    localparam logic [7:0]  OFF_INT_STAT  = 8'h1C;
    localparam logic [7:0]  OFF_INT_MASK  = 8'h20;
    localparam logic [7:0]  OFF_PIN_SEL   = 8'h24;
    // Control register 0 fields
    localparam int          C0_PAUSE      = 7;
    localparam int          C0_CLK_HI     = 6;
    localparam int          C0_CLK_LO     = 4;
    localparam int          C0_ON         = 3;
    localparam logic [7:0]  C0_MASK       = 8'hF8;
    // Control register 1 fields
    localparam int          C1_MODE_HI    = 7;
    localparam int          C1_MODE_LO    = 6;
    localparam int          C1_FUNC_HI    = 5;
    localparam int          C1_FUNC_LO    = 4;
    localparam int          C1_OC         = 3;
    localparam int          C1_POL        = 2;
    localparam int          C1_DPX        = 1;
    localparam int          C1_CCLR       = 0;
    // Interrupt bits
    localparam int          IRQ_A         = 0;
    localparam int          IRQ_P         = 1;
    // Pin-sharing selection bits
    localparam int          PS_CLK_EN     = 0;
    localparam int          PS_CAP_EN     = 1;
    localparam int          PS_OUT_EN     = 2;
    localparam int          PS_CAP_CLKPIN = 3;
    localparam logic [7:0]  RST_BYTE      = 8'h00;
    localparam logic [15:0] RST_WORD      = 16'h0000;
    localparam logic [5:0]  PRE_DIV4      = 6'h03;
    localparam logic [5:0]  PRE_DIV16     = 6'h0F;
    localparam logic [5:0]  PRE_DIV64     = 6'h3F;

    typedef enum logic [1:0] {
        TMC_MODE_CMP   = 2'b00,
        TMC_MODE_CAP   = 2'b01,
        TMC_MODE_PWM   = 2'b10,
        TMC_MODE_TIMER = 2'b11
    } tmc_mode_t;

    typedef enum logic [2:0] {
        TMC_CLK_SYS4  = 3'b000,
        TMC_CLK_SYS   = 3'b001,
        TMC_CLK_H16   = 3'b010,
        TMC_CLK_H64   = 3'b011,
        TMC_CLK_SUB0  = 3'b100,
        TMC_CLK_SUB1  = 3'b101,
        TMC_CLK_PINR  = 3'b110,
        TMC_CLK_PINF  = 3'b111
    } tmc_clk_t;
endpackage : tmc_pkg
`default_nettype wire

// ==== hw/tmc_timer.sv ====
// The APB interface to the registers and the address map were chosen for this implementation.
`default_nettype none
module tmc_timer #(
    parameter bit HAS_INV_OUT = 1'b1
) (
    input  wire logic        I_CLK,
    input  wire logic        I_ARST_N,
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [7:0]  I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic      [31:0] O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    input  wire logic        I_SUB_CLK,
    input  wire logic        I_TIMER_CLOCK_INPUT_PIN,
    input  wire logic        I_TIMER_CAPTURE_INPUT_PIN,
    output logic             O_TIMER_OUTPUT_PIN,
    output logic             O_TIMER_OUTPUT_PIN_OE,
    output logic             O_TIMER_INVERTED_OUTPUT_PIN,
    output logic             O_TIMER_INVERTED_OUTPUT_PIN_OE,
    output logic             O_IRQ
);
    function automatic logic is_off(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction : is_off

    logic [7:0]  ctrl0_ff;
    logic [7:0]  ctrl1_ff;
    logic [15:0] cmpa_ff;
    logic [7:0]  cmpp_ff;
    logic [7:0]  buf_ff;
    logic [7:0]  snap_ff;
    logic [1:0]  stat_ff;
    logic [1:0]  mask_ff;
    logic [3:0]  pinsel_ff;
    logic [15:0] cnt_ff;
    logic [5:0]  pre_ff;
    logic        on_d_ff;
    logic        out_ff;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic        irq_ff;
    logic        opin_ff;
    logic        oinv_ff;
    logic        oe_ff;
    logic        oe_inv_ff;

    logic        sub_rise;
    logic        ck_rise;
    logic        ck_fall;
    logic        cp_rise;
    logic        cp_fall;

    tmc_edge_sync u_sub_sync (
        .i_clk    (I_CLK),
        .i_arst_n (I_ARST_N),
        .i_pin    (I_SUB_CLK),
        .o_rise   (sub_rise),
        .o_fall   ()
    );

    tmc_edge_sync u_clk_sync (
        .i_clk    (I_CLK),
        .i_arst_n (I_ARST_N),
        .i_pin    (I_TIMER_CLOCK_INPUT_PIN),
        .o_rise   (ck_rise),
        .o_fall   (ck_fall)
    );

    tmc_edge_sync u_cap_sync (
        .i_clk    (I_CLK),
        .i_arst_n (I_ARST_N),
        .i_pin    (I_TIMER_CAPTURE_INPUT_PIN),
        .o_rise   (cp_rise),
        .o_fall   (cp_fall)
    );

    // Field views
    tmc_pkg::tmc_mode_t mode;
    tmc_pkg::tmc_clk_t  clk_sel;
    logic [1:0] func;
    logic       on;
    logic       pause;
    logic       oc;
    logic       pol;
    logic       dpx;
    logic       cclr;

    assign mode    = tmc_pkg::tmc_mode_t'(ctrl1_ff[tmc_pkg::C1_MODE_HI:tmc_pkg::C1_MODE_LO]);
    assign clk_sel = tmc_pkg::tmc_clk_t'(ctrl0_ff[tmc_pkg::C0_CLK_HI:tmc_pkg::C0_CLK_LO]);
    assign func    = ctrl1_ff[tmc_pkg::C1_FUNC_HI:tmc_pkg::C1_FUNC_LO];
    assign on      = ctrl0_ff[tmc_pkg::C0_ON];
    assign pause   = ctrl0_ff[tmc_pkg::C0_PAUSE];
    assign oc      = ctrl1_ff[tmc_pkg::C1_OC];
    assign pol     = ctrl1_ff[tmc_pkg::C1_POL];
    assign dpx     = ctrl1_ff[tmc_pkg::C1_DPX];
    assign cclr    = ctrl1_ff[tmc_pkg::C1_CCLR];

    // Pins only reach the timer once selected through pin sharing
    logic ck_r_en;
    logic ck_f_en;
    logic cp_r_en;
    logic cp_f_en;
    assign ck_r_en = ck_rise & pinsel_ff[tmc_pkg::PS_CLK_EN];
    assign ck_f_en = ck_fall & pinsel_ff[tmc_pkg::PS_CLK_EN];
    assign cp_r_en = pinsel_ff[tmc_pkg::PS_CAP_CLKPIN] ? ck_r_en :
                     (cp_rise & pinsel_ff[tmc_pkg::PS_CAP_EN]);
    assign cp_f_en = pinsel_ff[tmc_pkg::PS_CAP_CLKPIN] ? ck_f_en :
                     (cp_fall & pinsel_ff[tmc_pkg::PS_CAP_EN]);

    // APB decode
    logic setup;
    logic acc;
    logic wr;
    logic rd;
    logic mapped;
    assign setup = I_PSEL & ~I_PENABLE;
    assign acc   = I_PSEL & I_PENABLE & pready_ff;
    assign wr    = acc & I_PWRITE;
    assign rd    = acc & ~I_PWRITE;

    // Count tick; the high clock is taken equal to the system clock here
    logic tick;
    always_comb begin
        unique case (clk_sel)
            tmc_pkg::TMC_CLK_SYS4: tick = (pre_ff[1:0] == tmc_pkg::PRE_DIV4[1:0]);
            tmc_pkg::TMC_CLK_SYS:  tick = 1'b1;
            tmc_pkg::TMC_CLK_H16:  tick = (pre_ff[3:0] == tmc_pkg::PRE_DIV16[3:0]);
            tmc_pkg::TMC_CLK_H64:  tick = (pre_ff == tmc_pkg::PRE_DIV64);
            tmc_pkg::TMC_CLK_SUB0: tick = sub_rise;
            tmc_pkg::TMC_CLK_SUB1: tick = sub_rise;
            tmc_pkg::TMC_CLK_PINR: tick = ck_r_en;
            tmc_pkg::TMC_CLK_PINF: tick = ck_f_en;
        endcase
    end

    logic        run;
    logic        on_rise;
    logic [15:0] cnt_inc;
    logic        a_hit;
    logic        p_hit;
    logic        clr_hit;
    logic        period_hit;
    logic        duty_hit;
    logic        cap_evt;
    logic        sp_trig;
    logic        is_pwm;

    assign run     = on & ~pause;
    assign on_rise = on & ~on_d_ff;
    assign cnt_inc = cnt_ff + 16'h0001;
    assign is_pwm  = (mode == tmc_pkg::TMC_MODE_PWM);
    // Matches are judged on the value the counter is about to take
    assign a_hit   = run & tick & (cnt_inc == cmpa_ff);
    assign p_hit   = run & tick & (cnt_inc[15:8] == cmpp_ff) & (cnt_inc[7:0] == 8'h00);
    assign period_hit = dpx ? a_hit : p_hit;
    assign duty_hit   = dpx ? p_hit : a_hit;
    assign clr_hit = is_pwm ? period_hit : (cclr ? a_hit : p_hit);
    assign sp_trig = is_pwm & (func == 2'b11) & on & ck_r_en;
    always_comb begin
        cap_evt = 1'b0;
        if ((mode == tmc_pkg::TMC_MODE_CAP) && on) begin
            unique case (func)
                2'b00: cap_evt = cp_r_en;
                2'b01: cap_evt = cp_f_en;
                2'b10: cap_evt = cp_r_en | cp_f_en;
                2'b11: cap_evt = 1'b0;
            endcase
        end
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            pre_ff  <= 6'h00;
            on_d_ff <= 1'b0;
        end else begin
            pre_ff  <= pre_ff + 6'h01;
            on_d_ff <= on;
        end
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            cnt_ff <= tmc_pkg::RST_WORD;
        end else if (on_rise || sp_trig) begin
            cnt_ff <= tmc_pkg::RST_WORD;
        end else if (run && tick) begin
            // Overflow wraps to zero by itself
            cnt_ff <= clr_hit ? tmc_pkg::RST_WORD : cnt_inc;
        end
    end

    // Output level before polarity; oc is the active level
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            out_ff <= 1'b0;
        end else begin
            unique case (mode)
                tmc_pkg::TMC_MODE_CMP: begin
                    if (on_rise) begin
                        out_ff <= oc;
                    end else if (a_hit) begin
                        unique case (func)
                            2'b00: out_ff <= out_ff;
                            2'b01: out_ff <= 1'b0;
                            2'b10: out_ff <= 1'b1;
                            2'b11: out_ff <= ~out_ff;
                        endcase
                    end
                end
                tmc_pkg::TMC_MODE_PWM: begin
                    unique case (func)
                        2'b00: out_ff <= ~oc;
                        2'b01: out_ff <= oc;
                        2'b10: begin
                            // Period wins a tie so a full duty stays active
                            if (on_rise || period_hit) begin
                                out_ff <= oc;
                            end else if (duty_hit) begin
                                out_ff <= ~oc;
                            end
                        end
                        2'b11: begin
                            if (sp_trig) begin
                                out_ff <= oc;
                            end else if (on_rise || a_hit) begin
                                out_ff <= ~oc;
                            end
                        end
                    endcase
                end
                tmc_pkg::TMC_MODE_CAP: out_ff <= oc;
                tmc_pkg::TMC_MODE_TIMER: out_ff <= oc;
            endcase
        end
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            opin_ff   <= 1'b0;
            oinv_ff   <= 1'b0;
            oe_ff     <= 1'b0;
            oe_inv_ff <= 1'b0;
        end else begin
            opin_ff   <= out_ff ^ pol;
            oinv_ff   <= HAS_INV_OUT & ~(out_ff ^ pol);
            oe_ff     <= pinsel_ff[tmc_pkg::PS_OUT_EN]
                         & (mode != tmc_pkg::TMC_MODE_TIMER)
                         & (mode != tmc_pkg::TMC_MODE_CAP);
            oe_inv_ff <= HAS_INV_OUT & pinsel_ff[tmc_pkg::PS_OUT_EN]
                         & (mode != tmc_pkg::TMC_MODE_TIMER)
                         & (mode != tmc_pkg::TMC_MODE_CAP);
        end
    end

    // Control and compare registers
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            ctrl0_ff  <= tmc_pkg::RST_BYTE;
            ctrl1_ff  <= tmc_pkg::RST_BYTE;
            cmpp_ff   <= tmc_pkg::RST_BYTE;
            mask_ff   <= 2'b00;
            pinsel_ff <= 4'h0;
        end else if (wr) begin
            if (is_off(I_PADDR, tmc_pkg::OFF_CTRL0)) begin
                ctrl0_ff <= I_PWDATA[7:0] & tmc_pkg::C0_MASK;
            end
            if (is_off(I_PADDR, tmc_pkg::OFF_CTRL1)) begin
                ctrl1_ff <= I_PWDATA[7:0];
            end
            if (is_off(I_PADDR, tmc_pkg::OFF_CMPP)) begin
                cmpp_ff <= I_PWDATA[7:0];
            end
            if (is_off(I_PADDR, tmc_pkg::OFF_INT_MASK)) begin
                mask_ff <= I_PWDATA[1:0];
            end
            if (is_off(I_PADDR, tmc_pkg::OFF_PIN_SEL)) begin
                pinsel_ff <= I_PWDATA[3:0];
            end
        end
    end

    // Capture takes priority over a software write in the same cycle
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            cmpa_ff <= tmc_pkg::RST_WORD;
        end else if (cap_evt) begin
            cmpa_ff <= cnt_ff;
        end else if (wr && is_off(I_PADDR, tmc_pkg::OFF_CMPA_H)) begin
            cmpa_ff <= {I_PWDATA[7:0], buf_ff};
        end
    end

    // One buffer shared by every low byte
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            buf_ff <= tmc_pkg::RST_BYTE;
        end else if (wr && is_off(I_PADDR, tmc_pkg::OFF_CMPA_L)) begin
            buf_ff <= I_PWDATA[7:0];
        end else if (rd && (is_off(I_PADDR, tmc_pkg::OFF_CNT_H)
                            || is_off(I_PADDR, tmc_pkg::OFF_CMPA_H))) begin
            buf_ff <= snap_ff;
        end
    end

    // Low byte frozen with the high byte when the read data is formed
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            snap_ff <= tmc_pkg::RST_BYTE;
        end else if (setup) begin
            snap_ff <= is_off(I_PADDR, tmc_pkg::OFF_CNT_H) ? cnt_ff[7:0] : cmpa_ff[7:0];
        end
    end

    // Sticky status; an event in the clearing cycle survives
    logic [1:0] nxt_stat;
    logic [1:0] stat_clr;
    assign stat_clr = (wr && is_off(I_PADDR, tmc_pkg::OFF_INT_STAT)) ? I_PWDATA[1:0] : 2'b00;
    always_comb begin
        nxt_stat = stat_ff & ~stat_clr;
        nxt_stat[tmc_pkg::IRQ_A] = nxt_stat[tmc_pkg::IRQ_A] | a_hit | cap_evt;
        nxt_stat[tmc_pkg::IRQ_P] = nxt_stat[tmc_pkg::IRQ_P] | p_hit;
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            stat_ff <= 2'b00;
            irq_ff  <= 1'b0;
        end else begin
            stat_ff <= nxt_stat;
            irq_ff  <= |(nxt_stat & mask_ff);
        end
    end

    // Read data; the low-byte addresses only ever show the buffer
    logic [7:0] rbyte;
    always_comb begin
        rbyte  = 8'h00;
        mapped = 1'b1;
        unique case (I_PADDR)
            tmc_pkg::OFF_CTRL0:    rbyte = ctrl0_ff;
            tmc_pkg::OFF_CTRL1:    rbyte = ctrl1_ff;
            tmc_pkg::OFF_CNT_L:    rbyte = buf_ff;
            tmc_pkg::OFF_CNT_H:    rbyte = cnt_ff[15:8];
            tmc_pkg::OFF_CMPA_L:   rbyte = buf_ff;
            tmc_pkg::OFF_CMPA_H:   rbyte = cmpa_ff[15:8];
            tmc_pkg::OFF_CMPP:     rbyte = cmpp_ff;
            tmc_pkg::OFF_INT_STAT: rbyte = {6'h00, stat_ff};
            tmc_pkg::OFF_INT_MASK: rbyte = {6'h00, mask_ff};
            tmc_pkg::OFF_PIN_SEL:  rbyte = {4'h0, pinsel_ff};
            default:               mapped = 1'b0;
        endcase
    end

    // Zero wait states: ready is raised for the access phase
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= setup;
            pslverr_ff <= setup & ~mapped;
            if (setup && !I_PWRITE) begin
                prdata_ff <= {24'h00_0000, rbyte};
            end
        end
    end

    assign O_PRDATA                       = prdata_ff;
    assign O_PREADY                       = pready_ff;
    assign O_PSLVERR                      = pslverr_ff;
    assign O_TIMER_OUTPUT_PIN             = opin_ff;
    assign O_TIMER_OUTPUT_PIN_OE          = oe_ff;
    assign O_TIMER_INVERTED_OUTPUT_PIN    = oinv_ff;
    assign O_TIMER_INVERTED_OUTPUT_PIN_OE = oe_inv_ff;
    assign O_IRQ                          = irq_ff;
endmodule : tmc_timer
`default_nettype wire

// ==== testbench/testbench.sv ====
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        clk_pin;
    logic        cap_pin;
    logic        sub_clk;
    logic        out_pin;
    logic        out_oe;
    logic        inv_pin;
    logic        inv_oe;
    logic        irq;
    logic [31:0] rdat;
    logic        rerr;
    int          miscompares = 0;
    int          check_count = 0;
    always #50 clk = ~clk;
    tmc_timer DUT (
        .I_CLK(clk), .I_ARST_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
        .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .I_SUB_CLK(sub_clk), .I_TIMER_CLOCK_INPUT_PIN(clk_pin),
        .I_TIMER_CAPTURE_INPUT_PIN(cap_pin), .O_TIMER_OUTPUT_PIN(out_pin),
        .O_TIMER_OUTPUT_PIN_OE(out_oe), .O_TIMER_INVERTED_OUTPUT_PIN(inv_pin),
        .O_TIMER_INVERTED_OUTPUT_PIN_OE(inv_oe), .O_IRQ(irq));
    tmc_pins u_pins (.i_clk(clk), .o_clk_pin(clk_pin), .o_cap_pin(cap_pin), .o_sub_clk(sub_clk));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Idle edge first, so a following call never drives psel twice in one step
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) miscompares++;
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        check(rdat, {24'h0, e});
    endtask : rd
    task automatic pulses(input int n);
        repeat (n) begin
            u_pins.set_clk(1'b1);
            u_pins.set_clk(1'b0);
        end
    endtask : pulses
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : test_done
    initial begin
        #(100 * 20000);
        miscompares++;
        test_done();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 0; a <= 36; a += 4) rd(8'(a), 8'h00);
        apb(1'b1, 8'h28, 8'hFF);
        check({31'h0, rerr}, 32'h1);
        apb(1'b0, 8'h28, 8'h00);
        check({31'h0, rerr}, 32'h1);
        wr(tmc_pkg::OFF_CMPA_L, 8'h34);
        wr(tmc_pkg::OFF_CMPA_H, 8'h12);
        rd(tmc_pkg::OFF_CMPA_H, 8'h12);
        rd(tmc_pkg::OFF_CMPA_L, 8'h34);
        wr(tmc_pkg::OFF_CMPA_L, 8'h56);
        rd(tmc_pkg::OFF_CMPA_H, 8'h12);
        rd(tmc_pkg::OFF_CMPA_L, 8'h34);
        rd(tmc_pkg::OFF_CNT_H, 8'h00);
        rd(tmc_pkg::OFF_CMPA_L, 8'h00);
        wr(tmc_pkg::OFF_CMPP, 8'hFF);
        wr(tmc_pkg::OFF_CTRL1, 8'hC0);
        wr(tmc_pkg::OFF_CTRL0, 8'h68);
        pulses(2);
        rd(tmc_pkg::OFF_CNT_H, 8'h00);
        rd(tmc_pkg::OFF_CNT_L, 8'h00);
        check({31'h0, out_oe}, 32'h0);
        wr(tmc_pkg::OFF_PIN_SEL, 8'h01);
        wr(tmc_pkg::OFF_CTRL0, 8'h00);
        wr(tmc_pkg::OFF_CTRL0, 8'h68);
        pulses(2);
        u_pins.set_clk(1'b1);
        rd(tmc_pkg::OFF_CNT_H, 8'h00);
        rd(tmc_pkg::OFF_CNT_L, 8'h03);
        wr(tmc_pkg::OFF_CTRL0, 8'h00);
        wr(tmc_pkg::OFF_CTRL0, 8'h78);
        u_pins.set_clk(1'b0);
        pulses(1);
        rd(tmc_pkg::OFF_CNT_H, 8'h00);
        rd(tmc_pkg::OFF_CNT_L, 8'h02);
        wr(tmc_pkg::OFF_CMPA_L, 8'h04);
        wr(tmc_pkg::OFF_CMPA_H, 8'h00);
        wr(tmc_pkg::OFF_CTRL1, 8'hC1);
        wr(tmc_pkg::OFF_INT_MASK, 8'h01);
        wr(tmc_pkg::OFF_CTRL0, 8'h00);
        wr(tmc_pkg::OFF_CTRL0, 8'h68);
        pulses(4);
        rd(tmc_pkg::OFF_INT_STAT, 8'h01);
        check({31'h0, irq}, 32'h1);
        wr(tmc_pkg::OFF_INT_MASK, 8'h02);
        repeat (3) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        wr(tmc_pkg::OFF_INT_STAT, 8'h01);
        rd(tmc_pkg::OFF_INT_STAT, 8'h00);
        wr(tmc_pkg::OFF_CMPA_L, 8'hFF);
        wr(tmc_pkg::OFF_CMPA_H, 8'hFF);
        wr(tmc_pkg::OFF_CMPP, 8'h01);
        wr(tmc_pkg::OFF_CTRL1, 8'hC0);
        wr(tmc_pkg::OFF_CTRL0, 8'h00);
        wr(tmc_pkg::OFF_CTRL0, 8'h18);
        repeat (300) @(posedge clk);
        rd(tmc_pkg::OFF_INT_STAT, 8'h02);
        check({31'h0, irq}, 32'h1);
        wr(tmc_pkg::OFF_CTRL0, 8'h00);
        wr(tmc_pkg::OFF_INT_MASK, 8'h00);
        repeat (3) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        wr(tmc_pkg::OFF_PIN_SEL, 8'h05);
        wr(tmc_pkg::OFF_CMPA_L, 8'h03);
        wr(tmc_pkg::OFF_CMPA_H, 8'h00);
        for (int f = 1; f < 4; f++) begin
            wr(tmc_pkg::OFF_CTRL0, 8'h00);
            wr(tmc_pkg::OFF_CTRL1, {2'b00, 2'(f), f == 1, 3'b001});
            wr(tmc_pkg::OFF_CTRL0, 8'h68);
            repeat (3) @(posedge clk);
            check({31'h0, out_pin}, {31'h0, f == 1});
            check({31'h0, out_oe}, 32'h1);
            check({31'h0, inv_oe}, 32'h1);
            pulses(3);
            repeat (4) @(posedge clk);
            check({31'h0, out_pin}, {31'h0, f != 1});
        end
        // Period of 256 clocks, duty or single pulse of 128
        wr(tmc_pkg::OFF_CMPA_L, 8'h80);
        wr(tmc_pkg::OFF_CMPA_H, 8'h00);
        wr(tmc_pkg::OFF_CMPP, 8'h01);
        for (int f = 2; f < 4; f++) begin
            wr(tmc_pkg::OFF_CTRL0, 8'h00);
            wr(tmc_pkg::OFF_CTRL1, {2'b10, 2'(f), 4'h8});
            wr(tmc_pkg::OFF_CTRL0, 8'h18);
            repeat (3) @(posedge clk);
            check({31'h0, out_pin}, {31'h0, f == 2});
            if (f == 3) u_pins.set_clk(1'b1);
            repeat (20) @(posedge clk);
            check({31'h0, out_pin}, 32'h1);
            check({31'h0, inv_pin}, 32'h0);
            repeat (150) @(posedge clk);
            check({31'h0, out_pin}, 32'h0);
        end
        u_pins.set_clk(1'b0);
        wr(tmc_pkg::OFF_CMPA_L, 8'hFF);
        wr(tmc_pkg::OFF_CMPA_H, 8'hFF);
        wr(tmc_pkg::OFF_CMPP, 8'hFF);
        wr(tmc_pkg::OFF_PIN_SEL, 8'h02);
        for (int f = 0; f < 4; f++) begin
            wr(tmc_pkg::OFF_CTRL0, 8'h00);
            wr(tmc_pkg::OFF_CTRL1, {2'b01, 2'(f), 4'h0});
            // Counter held still, so a captured value never matches later
            wr(tmc_pkg::OFF_CTRL0, 8'h68);
            wr(tmc_pkg::OFF_INT_STAT, 8'h03);
            u_pins.set_cap(1'b1);
            rd(tmc_pkg::OFF_INT_STAT, {7'h0, f == 0 || f == 2});
            wr(tmc_pkg::OFF_INT_STAT, 8'h03);
            u_pins.set_cap(1'b0);
            rd(tmc_pkg::OFF_INT_STAT, {7'h0, f == 1 || f == 2});
        end
        wr(tmc_pkg::OFF_PIN_SEL, 8'h09);
        wr(tmc_pkg::OFF_CTRL1, 8'h40);
        wr(tmc_pkg::OFF_INT_STAT, 8'h03);
        u_pins.set_clk(1'b1);
        rd(tmc_pkg::OFF_INT_STAT, 8'h01);
        test_done();
    end
endmodule : testbench
`default_nettype wire

// ==== testbench/tmc_chk.sv ====
`default_nettype none
module tmc_chk #(
    parameter bit HAS_INV_OUT = 1'b1
) (
    input wire logic        I_CLK,
    input wire logic        I_ARST_N,
    input wire logic        I_PSEL,
    input wire logic        I_PENABLE,
    input wire logic        I_PWRITE,
    input wire logic [7:0]  I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic [31:0] O_PRDATA,
    input wire logic        O_PREADY,
    input wire logic        O_PSLVERR,
    input wire logic        O_TIMER_OUTPUT_PIN,
    input wire logic        O_TIMER_OUTPUT_PIN_OE,
    input wire logic        O_TIMER_INVERTED_OUTPUT_PIN,
    input wire logic        O_TIMER_INVERTED_OUTPUT_PIN_OE,
    input wire logic        O_IRQ
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_ARST_N);
    sequence s_setup;
        I_PSEL && !I_PENABLE;
    endsequence
    sequence s_mask_off;
        I_PSEL && I_PENABLE && I_PWRITE && O_PREADY && I_PADDR == tmc_pkg::OFF_INT_MASK
            && I_PWDATA[1:0] == 2'b00;
    endsequence
    chk_ready_after_setup: assert property (s_setup |=> O_PREADY)
        else $error("no ready in access cycle");
    chk_ready_one_cycle: assert property (O_PREADY |-> I_PSEL && I_PENABLE ##1 !O_PREADY)
        else $error("ready outside a single access cycle");
    chk_err_on_unmapped: assert property (O_PREADY |-> O_PSLVERR ==
        (I_PADDR > tmc_pkg::OFF_PIN_SEL || I_PADDR[1:0] != 2'b00))
        else $error("error response does not match address");
    chk_err_read_zero: assert property (O_PSLVERR && !I_PWRITE |-> O_PRDATA == 32'h0)
        else $error("refused read returned data");
    chk_rdata_holds: assert property ($changed(O_PRDATA) |-> O_PREADY && !I_PWRITE)
        else $error("read data moved without a read");
    chk_rdata_byte: assert property (O_PREADY |-> O_PRDATA[31:8] == 24'h0)
        else $error("read data above byte lane");
    chk_inv_complement: assert property (O_TIMER_INVERTED_OUTPUT_PIN_OE |->
        O_TIMER_INVERTED_OUTPUT_PIN != O_TIMER_OUTPUT_PIN)
        else $error("inverted pin not complement");
    chk_inv_oe_gate: assert property (O_TIMER_INVERTED_OUTPUT_PIN_OE ==
        (HAS_INV_OUT && O_TIMER_OUTPUT_PIN_OE))
        else $error("inverted pin enable wrong");
    chk_irq_masked: assert property (s_mask_off |=> ##1 !O_IRQ)
        else $error("interrupt stays up with mask clear");
endmodule : tmc_chk
bind tmc_timer tmc_chk #(.HAS_INV_OUT(HAS_INV_OUT)) u_chk (
    .I_CLK(I_CLK), .I_ARST_N(I_ARST_N), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
    .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA),
    .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_TIMER_OUTPUT_PIN(O_TIMER_OUTPUT_PIN),
    .O_TIMER_OUTPUT_PIN_OE(O_TIMER_OUTPUT_PIN_OE),
    .O_TIMER_INVERTED_OUTPUT_PIN(O_TIMER_INVERTED_OUTPUT_PIN),
    .O_TIMER_INVERTED_OUTPUT_PIN_OE(O_TIMER_INVERTED_OUTPUT_PIN_OE), .O_IRQ(O_IRQ));
`default_nettype wire

// ==== testbench/tmc_pins.sv ====
`default_nettype none
module tmc_pins (
    input  wire logic i_clk,
    output var logic  o_clk_pin,
    output var logic  o_cap_pin,
    output var logic  o_sub_clk
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] sub_div = 3'h0;
    initial o_clk_pin = 1'b0;
    initial o_cap_pin = 1'b0;
    initial o_sub_clk = 1'b0;
    // Sub clock oscillator runs free, far below the system rate
    always @(posedge i_clk) begin
        sub_div <= sub_div + 3'h1;
        if (sub_div == 3'h7) o_sub_clk <= ~o_sub_clk;
    end
    // Levels held five clocks so the synchroniser sees every edge once
    task automatic set_clk(input logic v);
        @(posedge i_clk);
        o_clk_pin <= v;
        repeat (4) @(posedge i_clk);
    endtask : set_clk
    task automatic set_cap(input logic v);
        @(posedge i_clk);
        o_cap_pin <= v;
        repeat (4) @(posedge i_clk);
    endtask : set_cap
endmodule : tmc_pins
`default_nettype wire
